// ---- hlc_line_ctrl.sv ----
`timescale 1ns/10ps
`include "hlc_map.svh"

// Behaviour
// [R01] Transceiver disable output is low exactly while select and read are both low.
// [R02] With no read in progress the transceiver disable output stays high.
// [R03] Host interrupt output is inactive unless the interrupt output enable bit is set.
// [R04] Host interrupt output follows pending interrupt status like a classic UART.
// [R05] Both line transmit outputs turn off when transmitter disabled or analog loopback.
// [R06] Talk/data relay driver held off during reset and throughout sleep.
// [R07] Talk/data and off-hook relay drivers switch together in the same cycle.
// [R08] Off-hook relay driver held off during reset and throughout sleep.
// [R09] Off-hook relay driver asserted to take the line off-hook.
// [R10] A falling edge on the ring detect input leaves sleep mode.
// [R11] External ring detector signals a ringing voltage of about 15 to 63 Hz.
// [R12] Line-in-use indicator is low while the line is in use, high otherwise.
// [R13] Host drives active-low select and read strobe together to read a register.
// [R14] Ring detect input passes two flip-flops before falling edges are detected.
module hlc_line_ctrl
  import hlc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,

  // Host bus strobes
  input wire logic host_select_n,
  input wire logic host_read_n,
  output logic xcvr_drive_disable_n,

  // Interrupt path
  input wire logic irq_pending,
  input wire logic irq_output_enable,
  output logic host_irq_out,

  // Transmit path
  input wire logic tx_enable,
  input wire logic analog_loopback,
  input wire logic tx_pos_in,
  input wire logic tx_neg_in,
  output logic line_tx_pos,
  output logic line_tx_neg,
  output logic line_tx_on,

  // Hook control and power
  input wire logic off_hook_request,
  input wire logic sleep_request,
  input wire logic ring_detect,
  output logic sleep_active,
  output logic wake_event,

  // Relay drivers, open drain
  output logic hook_relay_drive_o,
  output logic hook_relay_drive_oe,
  output logic handset_relay_drive_o,
  output logic handset_relay_drive_oe,

  // Key telephone indicator
  output logic line_in_use_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic host_reading;
  logic tx_allowed;
  logic ring_fall;
  logic relay_want;
  logic ring_meta_ff;
  logic ring_sync_ff;
  logic ring_prev_ff;
  logic irq_ff;
  logic nxt_irq;
  logic tx_pos_ff;
  logic tx_neg_ff;
  logic tx_on_ff;
  logic nxt_tx_pos;
  logic nxt_tx_neg;
  logic relay_on_ff;
  logic nxt_relay_on;
  logic wake_ff;
  logic nxt_wake;
  hlc_pwr_state_t pwr_state_ff;
  hlc_pwr_state_t nxt_pwr_state;

  ////////////////////////////////////////////////////////////////////////////
  // Host bus transceiver control

  // Decoded straight from the pins so the transceiver turns round with the strobe
  assign host_reading = !host_select_n && !host_read_n; // [R13]
  assign xcvr_drive_disable_n = !host_reading; // [R01] [R02]

  ////////////////////////////////////////////////////////////////////////////
  // Host interrupt

  assign nxt_irq = irq_pending && irq_output_enable; // [R03] [R04]

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_ff <= `HLC_OFF;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  assign host_irq_out = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Line transmit outputs

  assign tx_allowed = tx_enable && !analog_loopback; // [R05]
  assign nxt_tx_pos = tx_allowed && tx_pos_in;
  assign nxt_tx_neg = tx_allowed && tx_neg_in;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_on_ff <= `HLC_OFF;
      tx_pos_ff <= `HLC_OFF;
      tx_neg_ff <= `HLC_OFF;
    end else begin
      tx_on_ff <= tx_allowed; // [R05]
      tx_pos_ff <= nxt_tx_pos;
      tx_neg_ff <= nxt_tx_neg;
    end
  end

  assign line_tx_on = tx_on_ff;
  assign line_tx_pos = tx_pos_ff;
  assign line_tx_neg = tx_neg_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Ring detect synchroniser and edge

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ring_meta_ff <= `HLC_RING_IDLE;
      ring_sync_ff <= `HLC_RING_IDLE;
      ring_prev_ff <= `HLC_RING_IDLE;
    end else begin
      ring_meta_ff <= ring_detect; // [R14]
      ring_sync_ff <= ring_meta_ff; // [R14]
      ring_prev_ff <= ring_sync_ff;
    end
  end

  // Ringing cadence comes from the external detector; only its edge matters here
  assign ring_fall = ring_prev_ff && !ring_sync_ff; // [R11] [R14]

  ////////////////////////////////////////////////////////////////////////////
  // Power state

  // A wake edge in the same cycle as a sleep request keeps the device awake
  always_comb begin
    nxt_pwr_state = pwr_state_ff;
    nxt_wake = `HLC_OFF;
    unique case (pwr_state_ff)
      HLC_ST_AWAKE: begin
        if (sleep_request && !ring_fall) begin
          nxt_pwr_state = HLC_ST_SLEEP;
        end
      end
      HLC_ST_SLEEP: begin
        if (ring_fall) begin
          nxt_pwr_state = HLC_ST_AWAKE; // [R10]
          nxt_wake = `HLC_ON;
        end
      end
      default: begin
        nxt_pwr_state = HLC_ST_AWAKE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwr_state_ff <= HLC_ST_AWAKE;
      wake_ff <= `HLC_OFF;
    end else begin
      pwr_state_ff <= nxt_pwr_state;
      wake_ff <= nxt_wake;
    end
  end

  assign sleep_active = (pwr_state_ff == HLC_ST_SLEEP);
  assign wake_event = wake_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Relay drivers

  // The relay is clamped off in any cycle that will be spent asleep
  assign relay_want = off_hook_request; // [R09]
  assign nxt_relay_on = relay_want && (nxt_pwr_state == HLC_ST_AWAKE); // [R06] [R08]

  always_ff @(posedge core_clk) begin
    if (rst) begin
      relay_on_ff <= `HLC_OFF; // [R06] [R08]
    end else begin
      relay_on_ff <= nxt_relay_on;
    end
  end

  // One flop feeds both drivers so they can never switch apart
  assign hook_relay_drive_oe = relay_on_ff; // [R07] [R09]
  assign handset_relay_drive_oe = relay_on_ff; // [R07]
  assign hook_relay_drive_o = `HLC_OD_LEVEL;
  assign handset_relay_drive_o = `HLC_OD_LEVEL;

  // Line in use whenever the modem holds the line off-hook
  assign line_in_use_n = !relay_on_ff; // [R12]

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb_core @(posedge core_clk);
  endclocking

  default disable iff (rst);

  property p_xcvr_read;
    (!host_select_n && !host_read_n) |-> !xcvr_drive_disable_n;
  endproperty
  a_xcvr_read: assert property (p_xcvr_read) // [R01]
    else $error("Transceiver disable not low during host read");

  property p_xcvr_idle;
    (host_select_n || host_read_n) |-> xcvr_drive_disable_n;
  endproperty
  a_xcvr_idle: assert property (p_xcvr_idle) // [R02]
    else $error("Transceiver disable not high outside host read");

  property p_irq_gate;
    !irq_output_enable |=> !host_irq_out;
  endproperty
  a_irq_gate: assert property (p_irq_gate) // [R03]
    else $error("Interrupt output active while output enable clear");

  property p_irq_follow;
    irq_output_enable |=> (host_irq_out == $past(irq_pending));
  endproperty
  a_irq_follow: assert property (p_irq_follow) // [R04]
    else $error("Interrupt output does not follow pending status");

  property p_tx_off;
    (!tx_enable || analog_loopback) |=> (!line_tx_on && !line_tx_pos && !line_tx_neg);
  endproperty
  a_tx_off: assert property (p_tx_off) // [R05]
    else $error("Line transmit outputs not off");

  property p_tx_pass;
    (tx_enable && !analog_loopback) |=>
      (line_tx_on && line_tx_pos == $past(tx_pos_in) && line_tx_neg == $past(tx_neg_in));
  endproperty
  a_tx_pass: assert property (p_tx_pass) // [R05]
    else $error("Line transmit output not passing data when enabled");

  property p_sleep_clamp;
    sleep_active |-> (!hook_relay_drive_oe && !handset_relay_drive_oe);
  endproperty
  a_sleep_clamp: assert property (p_sleep_clamp) // [R06] [R08]
    else $error("Relay driven during sleep");

  property p_reset_clamp;
    $fell(rst) |-> (!hook_relay_drive_oe && !handset_relay_drive_oe && line_in_use_n);
  endproperty
  a_reset_clamp: assert property (p_reset_clamp) // [R06] [R08]
    else $error("Relay driven right after reset");

  property p_relay_pair;
    $changed(hook_relay_drive_oe) |-> $changed(handset_relay_drive_oe);
  endproperty
  a_relay_pair: assert property (p_relay_pair) // [R07]
    else $error("Relay drivers switched apart");

  property p_hook_on;
    (off_hook_request && !sleep_active && !sleep_request) |=> hook_relay_drive_oe;
  endproperty
  a_hook_on: assert property (p_hook_on) // [R09]
    else $error("Off-hook relay not driven on request");

  sequence s_sleep_fall;
    ring_sync_ff ##1 (!ring_sync_ff && sleep_active);
  endsequence

  property p_wake;
    s_sleep_fall |=> (!sleep_active && wake_event);
  endproperty
  a_wake: assert property (p_wake) // [R10]
    else $error("Ring falling edge did not end sleep");

  property p_in_use;
    line_in_use_n == !hook_relay_drive_oe;
  endproperty
  a_in_use: assert property (p_in_use) // [R12]
    else $error("Line in use indicator disagrees with hook state");

  sequence s_ring_drop;
    $fell(ring_detect);
  endsequence

  property p_ring_sync;
    s_ring_drop |-> ##2 $fell(ring_sync_ff);
  endproperty
  a_ring_sync: assert property (p_ring_sync) // [R14]
    else $error("Ring input not delayed by two flip-flops");

endmodule

// ---- hlc_map.svh ----
`ifndef HLC_MAP_SVH
`define HLC_MAP_SVH

// Driver levels
`define HLC_OFF 1'b0
`define HLC_ON 1'b1

// Idle level of active-low outputs and of the ring pin
`define HLC_N_IDLE 1'b1
`define HLC_RING_IDLE 1'b1

// Open-drain relay pins only ever pull low
`define HLC_OD_LEVEL 1'b0

// One-hot power state codes
`define HLC_ST_AWAKE_CODE 2'b01
`define HLC_ST_SLEEP_CODE 2'b10

`endif

// ---- hlc_pkg.sv ----
`include "hlc_map.svh"

package hlc_pkg;

  typedef enum logic [1:0] {
    HLC_ST_AWAKE = `HLC_ST_AWAKE_CODE,
    HLC_ST_SLEEP = `HLC_ST_SLEEP_CODE
  } hlc_pwr_state_t;

endpackage

// ---- hlc_host_bfm.sv ----
`timescale 1ns/10ps
module hlc_host_bfm (
  // Clock
  input wire logic core_clk,
  // Access choice from the bench
  input wire logic [1:0] pick,
  input wire logic stray,
  // Host strobes
  output logic host_select_n,
  output logic host_read_n
);
  // Read strobe only under select, unless a stray strobe is commanded
  // Pins follow the bench's choice at once, so they move on the falling edge with it
  always_comb begin
    host_select_n = pick[0];
    host_read_n = pick[1] | (pick[0] & ~stray);
  end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top
  import hlc_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic pend = 1'b0, oen = 1'b0, txe = 1'b0, lb = 1'b0, tp = 1'b0, tn = 1'b0;
  logic offh = 1'b0, slp = 1'b0, ring = 1'b1, stray = 1'b0;
  logic [1:0] pick = 2'h0;
  logic sel_n, rd_n, xdis, irq, txp, txn, txon, sa, wk, ho, hoe, to, toe, liu;
  int error_cnt = 0;
  int cmp_count = 0;
  int hold = 0;
  logic [31:0] lf = 32'hc812_d25d;
  logic [11:0] q[$];
  logic [11:0] e;
  logic m = 1'b1, s = 1'b1, sd = 1'b1;
  hlc_pwr_state_t st = HLC_ST_AWAKE;

  always #5 core_clk = ~core_clk;

  hlc_host_bfm host (.core_clk(core_clk), .pick(pick), .stray(stray),
    .host_select_n(sel_n), .host_read_n(rd_n));

  hlc_line_ctrl dut (.core_clk(core_clk), .rst(rst), .host_select_n(sel_n),
    .host_read_n(rd_n), .xcvr_drive_disable_n(xdis), .irq_pending(pend),
    .irq_output_enable(oen), .host_irq_out(irq), .tx_enable(txe),
    .analog_loopback(lb), .tx_pos_in(tp), .tx_neg_in(tn), .line_tx_pos(txp),
    .line_tx_neg(txn), .line_tx_on(txon), .off_hook_request(offh),
    .sleep_request(slp), .ring_detect(ring), .sleep_active(sa), .wake_event(wk),
    .hook_relay_drive_o(ho), .hook_relay_drive_oe(hoe), .handset_relay_drive_o(to),
    .handset_relay_drive_oe(toe), .line_in_use_n(liu));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Drive one cycle of stimulus and note what the next edge must produce
  task automatic step(input logic r);
    logic w, on, h, fall;
    lf = lfsr(lf);
    rst = r;
    pick = lf[1:0];
    stray = lf[2] & lf[3];
    pend = lf[4];
    oen = lf[5];
    txe = lf[6] | lf[7];
    lb = lf[8] & lf[9];
    tp = lf[10];
    tn = lf[11];
    offh = lf[12] | lf[13];
    slp = (lf[19:16] == 4'h0);
    // Ring pulses stay low for at least four cycles
    if (hold == 0 && lf[24:20] == 5'h00) hold = 4 + lf[26:25];
    else if (hold > 0) hold--;
    ring = (hold == 0);
    fall = sd & ~s;
    if (r) begin
      m = 1'b1;
      s = 1'b1;
      sd = 1'b1;
      st = HLC_ST_AWAKE;
      q.push_back({pick != 2'h0, 11'h004});
    end else begin
      w = (st == HLC_ST_SLEEP) && fall;
      if (w) st = HLC_ST_AWAKE;
      else if (st == HLC_ST_AWAKE && slp && !fall) st = HLC_ST_SLEEP;
      on = txe & ~lb;
      h = offh && (st == HLC_ST_AWAKE);
      q.push_back({pick != 2'h0, pend & oen, on, tp & on, tn & on,
                   st == HLC_ST_SLEEP, w, h, h, ~h, 2'b00});
      sd = s;
      s = m;
      m = ring;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    #1;
    if (q.size() > 0) begin
      e = q.pop_front();
      check({10'h000, xdis}, {10'h000, e[11]});
      check({irq, txon, txp, txn, sa, wk, hoe, toe, liu, ho, to}, e[10:0]);
    end
  end

  initial begin
    repeat (8) begin
      @(negedge core_clk);
      step(1'b1);
    end
    for (int i = 0; i < 4000; i++) begin
      @(negedge core_clk);
      step(i == 2000 || i == 2001);
    end
    repeat (2) @(negedge core_clk);
    conclude();
  end
endmodule
